// ==== core/diag_display_regs.vh ====
`ifndef DIAG_DISPLAY_REGS_VH
`define DIAG_DISPLAY_REGS_VH

// ****************************************************************
// Timing
// ****************************************************************
`define DD_CLK_MHZ      200
`define DD_HOLD_MS      2000
`define DD_DEBOUNCE_MS  10

// ****************************************************************
// Screen numbers
// ****************************************************************
`define DD_SCR_TURBINE  3'h0
`define DD_SCR_OUTPUT   3'h1
`define DD_SCR_BATTERY  3'h2
`define DD_SCR_INPUTS   3'h3
`define DD_SCR_ENGINE   3'h4
`define DD_SCR_RATIO    3'h5
`define DD_SCR_LAST_BASE 3'h3
`define DD_SCR_LAST_EXT  3'h5

// ****************************************************************
// Segment codes, bit order g f e d c b a
// ****************************************************************
`define DD_SEG_BLANK    7'h00
`define DD_SEG_DASH     7'h40
`define DD_SEG_UPPER_T  7'h78
`define DD_SEG_LETTER_S 7'h6d
`define DD_SEG_LETTER_O 7'h3f
`define DD_SEG_LOWER_B  7'h7c
`define DD_SEG_LETTER_A 7'h77
`define DD_SEG_LOWER_I  7'h10
`define DD_SEG_LETTER_E 7'h79
`define DD_SEG_LOWER_R  7'h50
`define DD_SEG_LETTER_F 7'h71

// Segment bit positions used by the input check screen.
`define DD_SEG_A 0
`define DD_SEG_B 1
`define DD_SEG_C 2
`define DD_SEG_D 3
`define DD_SEG_E 4
`define DD_SEG_F 5

// Speed and battery formatting limits.
`define DD_RPM_TENS_MAX 14'h03e3
`define DD_TWO_DIGIT_MAX 8'h63
`define DD_DOT_TENTHS   4'h5

`endif

// ==== core/press_timer.v ====
`timescale 1ns/10ps
// ****************************************************************
// Push-button debounce and hold timer
// ****************************************************************
module press_timer #(
    parameter DEB_CYCLES  = 2000000,
    parameter HOLD_CYCLES = 400000000
) (
    input  wire ref_clk,
    input  wire sys_rst,
    input  wire raw_button,
    output wire held,
    output wire long_held,
    output reg  short_rel_r,
    output reg  long_rel_r
);
    reg        level_r;    // Debounced button level.
    reg [31:0] deb_cnt_r;  // Cycles the raw level has differed.
    reg [31:0] hold_cnt_r; // Cycles the button has been held.
    reg        long_r;     // Hold time has passed the limit.

    assign held      = level_r;
    assign long_held = long_r;

    // A change is accepted only once it has been stable for the
    // whole debounce time, so contact bounce never counts as a press.
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            level_r     <= 1'b0;
            deb_cnt_r   <= 32'h0;
            hold_cnt_r  <= 32'h0;
            long_r      <= 1'b0;
            short_rel_r <= 1'b0;
            long_rel_r  <= 1'b0;
        end else begin
            short_rel_r <= 1'b0;
            long_rel_r  <= 1'b0;
            if (raw_button == level_r) begin
                deb_cnt_r <= 32'h0;
            end else if (deb_cnt_r >= DEB_CYCLES - 1) begin
                deb_cnt_r <= 32'h0;
                level_r   <= raw_button;
                // The release edge chooses between advance and error.
                if (!raw_button) begin
                    short_rel_r <= ~long_r;
                    long_rel_r  <= long_r;
                end
            end else begin
                deb_cnt_r <= deb_cnt_r + 32'h1;
            end
            // Hold time saturates so very long holds stay long.
            if (!level_r) begin
                hold_cnt_r <= 32'h0;
                long_r     <= 1'b0;
            end else if (hold_cnt_r >= HOLD_CYCLES - 1) begin
                long_r <= 1'b1;
            end else begin
                hold_cnt_r <= hold_cnt_r + 32'h1;
            end
        end
    end
endmodule // press_timer

// ==== core/diag_display_formatter.v ====
`timescale 1ns/10ps
`include "diag_display_regs.vh"
// ****************************************************************
// Diagnostic screen selection and seven-segment formatting
// ****************************************************************
module diag_display_formatter #(
    parameter DEB_CYCLES  = `DD_DEBOUNCE_MS * `DD_CLK_MHZ * 1000,
    parameter HOLD_CYCLES = `DD_HOLD_MS * `DD_CLK_MHZ * 1000
) (
    input  wire        ref_clk,
    input  wire        sys_rst,
    input  wire        mode_button,
    input  wire [13:0] turbine_rpm,
    input  wire        turbine_ok,
    input  wire [13:0] output_rpm,
    input  wire        output_ok,
    input  wire [13:0] engine_rpm,
    input  wire        engine_ok,
    input  wire        engine_fitted,
    input  wire [9:0]  switched_supply_line,
    input  wire [7:0]  digital_in,
    input  wire [3:0]  analog_as_digital,
    input  wire [3:0]  analog_active,
    output reg  [6:0]  digit_hi_r,
    output reg  [6:0]  digit_lo_r,
    output reg         unit_dot_r,
    output reg         diag_led_r,
    output wire        normal_mode,
    output wire        diag_mode,
    output wire        error_mode,
    output wire [2:0]  screen_idx
);
    // ************************************************************
    // Modes
    // ************************************************************
    localparam ST_START  = 2'h0;
    localparam ST_NORMAL = 2'h1;
    localparam ST_DIAG   = 2'h2;
    localparam ST_ERROR  = 2'h3;

    reg  [1:0] mode_r;     // Current display mode.
    reg  [1:0] mode_nxt;   // Next display mode.
    reg  [2:0] screen_r;   // Current diagnostic screen.
    reg  [2:0] screen_nxt; // Next diagnostic screen.
    reg        armed_r;    // Button released once since power-up.
    wire       held;       // Debounced button level.
    wire       long_held;  // Button held past the long limit.
    wire       short_rel;  // Short release pulse.
    wire       long_rel;   // Long release pulse.
    wire [2:0] last_scr;   // Last screen of the active list.

    assign normal_mode = (mode_r == ST_NORMAL);
    assign diag_mode   = (mode_r == ST_DIAG);
    assign error_mode  = (mode_r == ST_ERROR);
    assign screen_idx  = screen_r;

    // The list grows by the engine and ratio screens when engine
    // speed is fitted, from a sensor or from a bus message.
    assign last_scr = engine_fitted ? `DD_SCR_LAST_EXT
                                    : `DD_SCR_LAST_BASE;

    press_timer #(
        .DEB_CYCLES  (DEB_CYCLES),
        .HOLD_CYCLES (HOLD_CYCLES)
    ) u_press (
        .ref_clk     (ref_clk),
        .sys_rst     (sys_rst),
        .raw_button  (mode_button),
        .held        (held),
        .long_held   (long_held),
        .short_rel_r (short_rel),
        .long_rel_r  (long_rel)
    );

    // ************************************************************
    // Mode and screen sequencing
    // ************************************************************
    // The start state looks at the button once, in the first cycle
    // after reset, so the strap is taken by a clocked process.
    always @* begin
        mode_nxt   = mode_r;
        screen_nxt = screen_r;
        case (mode_r)
            ST_START: begin
                if (mode_button) begin
                    mode_nxt = ST_DIAG;
                end else begin
                    mode_nxt = ST_NORMAL;
                end
                screen_nxt = `DD_SCR_TURBINE;
            end
            ST_DIAG: begin
                if (armed_r && long_rel) begin
                    mode_nxt = ST_ERROR;
                end else if (armed_r && short_rel) begin
                    if (screen_r >= last_scr) begin
                        screen_nxt = `DD_SCR_TURBINE;
                    end else begin
                        screen_nxt = screen_r + 3'h1;
                    end
                end else if (screen_r > last_scr) begin
                    // Engine speed dropped out of the list.
                    screen_nxt = `DD_SCR_TURBINE;
                end
            end
            ST_NORMAL: begin
                if (armed_r && long_rel) begin
                    mode_nxt = ST_ERROR;
                end
            end
            default: begin
                mode_nxt = mode_r;
            end
        endcase
    end

    // A hold that began at power-up only chose the mode; its own
    // release must not also step the screen, hence the arming flag.
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            mode_r   <= ST_START;
            screen_r <= `DD_SCR_TURBINE;
            armed_r  <= 1'b0;
        end else begin
            mode_r   <= mode_nxt;
            screen_r <= screen_nxt;
            if (mode_r != ST_START && !held && !mode_button) begin
                armed_r <= 1'b1;
            end
        end
    end

    // ************************************************************
    // Formatting helpers
    // ************************************************************
    // Decimal digit to segment code.
    function [6:0] seg_digit;
        input [3:0] d;
        begin
            case (d)
                4'h0: seg_digit = 7'h3f;
                4'h1: seg_digit = 7'h06;
                4'h2: seg_digit = 7'h5b;
                4'h3: seg_digit = 7'h4f;
                4'h4: seg_digit = 7'h66;
                4'h5: seg_digit = 7'h6d;
                4'h6: seg_digit = 7'h7d;
                4'h7: seg_digit = 7'h07;
                4'h8: seg_digit = 7'h7f;
                4'h9: seg_digit = 7'h6f;
                default: seg_digit = `DD_SEG_BLANK;
            endcase
        end
    endfunction

    // Two-digit value, clamped to 99, into {high, low} segments.
    function [13:0] seg_pair;
        input [7:0] v;
        reg   [7:0] c; // Value clamped to two digits.
        reg   [7:0] q; // Tens digit.
        reg   [7:0] r; // Units digit.
        begin
            c = (v > `DD_TWO_DIGIT_MAX) ? `DD_TWO_DIGIT_MAX : v;
            q = c / 8'h0a;
            r = c % 8'h0a;
            // Both digits are below ten after the clamp, so four bits hold them.
            seg_pair = {seg_digit(q[3:0]), seg_digit(r[3:0])};
        end
    endfunction

    // Speed into {dot, high, low}. Rounding to the nearest step
    // means 995 to 999 rpm already reads as 1.0 thousand.
    function [14:0] fmt_speed;
        input [13:0] rpm;
        input        ok;
        reg   [14:0] t;
        begin
            t = 15'h0000;
            if (!ok) begin
                fmt_speed = {1'b0, `DD_SEG_DASH, `DD_SEG_DASH};
            end else if (rpm < `DD_RPM_TENS_MAX) begin
                t = ({1'b0, rpm} + 15'h0005) / 15'h000a;
                fmt_speed = {1'b0, seg_pair(t[7:0])};
            end else begin
                t = ({1'b0, rpm} + 15'h0032) / 15'h0064;
                fmt_speed = {1'b1, seg_pair(t[7:0])};
            end
        end
    endfunction

    // ************************************************************
    // Live values per screen
    // ************************************************************
    wire [14:0] turb_fmt;   // Turbine speed digits.
    wire [14:0] outp_fmt;   // Output speed digits.
    wire [14:0] eng_fmt;    // Engine speed digits.
    wire [9:0]  volts;      // Whole volts of the switched line.
    wire [9:0]  tenths;     // Tenths of a volt.
    reg  [6:0]  check_hi;   // Input check, left digit.
    reg  [6:0]  check_lo;   // Input check, right digit.
    wire [3:0]  ana_lit;    // Analogue inputs lit on the check.

    // Neutral and sensor faults arrive folded into turbine_ok.
    assign turb_fmt = fmt_speed(turbine_rpm, turbine_ok);
    assign outp_fmt = fmt_speed(output_rpm, output_ok);
    assign eng_fmt  = fmt_speed(engine_rpm, engine_ok);

    // The battery value is the switched line, in tenths of a volt.
    assign volts  = switched_supply_line / 10'h00a;
    assign tenths = switched_supply_line % 10'h00a;

    // Only analogue inputs configured as digital can light.
    assign ana_lit = analog_as_digital & analog_active;

    // Even inputs take upper verticals, odd ones lower verticals;
    // analogue inputs take the top and bottom bars.
    always @* begin
        check_hi = `DD_SEG_BLANK;
        check_lo = `DD_SEG_BLANK;
        check_hi[`DD_SEG_F] = digital_in[0];
        check_hi[`DD_SEG_E] = digital_in[1];
        check_hi[`DD_SEG_B] = digital_in[2];
        check_hi[`DD_SEG_C] = digital_in[3];
        check_lo[`DD_SEG_F] = digital_in[4];
        check_lo[`DD_SEG_E] = digital_in[5];
        check_lo[`DD_SEG_B] = digital_in[6];
        check_lo[`DD_SEG_C] = digital_in[7];
        check_hi[`DD_SEG_A] = ana_lit[0];
        check_hi[`DD_SEG_D] = ana_lit[1];
        check_lo[`DD_SEG_A] = ana_lit[2];
        check_lo[`DD_SEG_D] = ana_lit[3];
    end

    // ************************************************************
    // Display selection
    // ************************************************************
    reg [14:0] show_nxt; // Next {dot, high, low}.

    // Once armed, while the button is down the screen label shows; past the
    // long limit the error-mode prompt shows so the user knows to
    // let go. Normal and error screens are formatted elsewhere.
    always @* begin
        show_nxt = {1'b0, `DD_SEG_BLANK, `DD_SEG_BLANK};
        if (mode_r == ST_DIAG && held && long_held) begin
            show_nxt = {1'b0, `DD_SEG_LETTER_A, `DD_SEG_LETTER_F};
        end else if (mode_r == ST_DIAG && held && armed_r) begin
            case (screen_r)
                `DD_SCR_TURBINE: show_nxt = {1'b0, `DD_SEG_UPPER_T,
                                             `DD_SEG_LETTER_S};
                `DD_SCR_OUTPUT:  show_nxt = {1'b0, `DD_SEG_LETTER_O,
                                             `DD_SEG_LETTER_S};
                `DD_SCR_BATTERY: show_nxt = {1'b0, `DD_SEG_LOWER_B,
                                             `DD_SEG_LETTER_A};
                `DD_SCR_INPUTS:  show_nxt = {1'b0, `DD_SEG_LOWER_I,
                                             `DD_SEG_UPPER_T};
                `DD_SCR_ENGINE:  show_nxt = {1'b0, `DD_SEG_LETTER_E,
                                             `DD_SEG_LETTER_S};
                default:         show_nxt = {1'b0, `DD_SEG_LETTER_S,
                                             `DD_SEG_LOWER_R};
            endcase
        end else if (mode_r == ST_DIAG) begin
            case (screen_r)
                `DD_SCR_TURBINE: show_nxt = turb_fmt;
                `DD_SCR_OUTPUT:  show_nxt = outp_fmt;
                `DD_SCR_BATTERY: show_nxt = {(tenths[3:0] >= `DD_DOT_TENTHS),
                                             seg_pair(volts[7:0])};
                `DD_SCR_INPUTS:  show_nxt = {1'b0, check_hi, check_lo};
                `DD_SCR_ENGINE:  show_nxt = eng_fmt;
                // The ratio value is produced elsewhere; dashes here.
                default:         show_nxt = {1'b0, `DD_SEG_DASH,
                                             `DD_SEG_DASH};
            endcase
        end
    end

    // Display outputs are registered to keep the pins glitch free.
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            digit_hi_r <= `DD_SEG_BLANK;
            digit_lo_r <= `DD_SEG_BLANK;
            unit_dot_r <= 1'b0;
            diag_led_r <= 1'b0;
        end else begin
            digit_hi_r <= show_nxt[13:7];
            digit_lo_r <= show_nxt[6:0];
            unit_dot_r <= show_nxt[14];
            diag_led_r <= (mode_nxt == ST_DIAG) ||
                          (mode_nxt == ST_ERROR);
        end
    end
endmodule // diag_display_formatter

// ==== tb/display_monitor.sv ====
`timescale 1ns/10ps
// ********************
// Port checker
// ********************
module display_monitor (
    input logic        ref_clk,
    input logic        sys_rst,
    input logic        mode_button,
    input logic        turbine_ok,
    input logic [13:0] turbine_rpm,
    input logic        output_ok,
    input logic        engine_ok,
    input logic [9:0]  switched_supply_line,
    input logic [7:0]  digital_in,
    input logic [3:0]  analog_as_digital,
    input logic [3:0]  analog_active,
    input logic [6:0]  digit_hi_r,
    input logic [6:0]  digit_lo_r,
    input logic        unit_dot_r,
    input logic        diag_led_r,
    input logic        normal_mode,
    input logic        diag_mode,
    input logic        error_mode,
    input logic [2:0]  screen_idx
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    // Button released long enough for debounce and the digit register to settle.
    sequence s_quiet(c);
        (diag_mode && !mode_button && c)[*8];
    endsequence
    // Button held on the first screen, well short of the long-press limit.
    sequence s_press0;
        (diag_mode && mode_button && screen_idx == 3'h0)[*8];
    endsequence
    a_turb_dash: assert property (s_quiet(screen_idx == 3'h0 && !turbine_ok)
        |=> digit_hi_r == 7'h40 && digit_lo_r == 7'h40 && !unit_dot_r) else $error("turbine");
    a_out_dash: assert property (s_quiet(screen_idx == 3'h1 && !output_ok)
        |=> digit_hi_r == 7'h40 && digit_lo_r == 7'h40) else $error("output dashes");
    a_eng_dash: assert property (s_quiet(screen_idx == 3'h4 && !engine_ok)
        |=> digit_hi_r == 7'h40 && digit_lo_r == 7'h40) else $error("engine dashes");
    a_slow_nodot: assert property (s_quiet(screen_idx == 3'h0 && turbine_ok
        && turbine_rpm < 14'd990 && $stable(turbine_rpm)) |=> !unit_dot_r) else $error("dot");
    a_fast_dot: assert property (s_quiet(screen_idx == 3'h0 && turbine_ok
        && turbine_rpm >= 14'd1000 && $stable(turbine_rpm)) |=> unit_dot_r) else $error("dot");
    a_batt_dot: assert property (s_quiet(screen_idx == 3'h2
        && $stable(switched_supply_line)) |=> unit_dot_r == ($past(switched_supply_line)
        % 10 >= 5)) else $error("battery dot");
    a_input_seg: assert property (s_quiet(screen_idx == 3'h3 && $stable(digital_in))
        |=> {digit_lo_r[2], digit_lo_r[1], digit_lo_r[4], digit_lo_r[5], digit_hi_r[2],
        digit_hi_r[1], digit_hi_r[4], digit_hi_r[5]} == $past(digital_in)) else $error("inputs");
    a_analog_seg: assert property (s_quiet(screen_idx == 3'h3
        && $stable(analog_as_digital) && $stable(analog_active)) |=> {digit_lo_r[3],
        digit_lo_r[0], digit_hi_r[3], digit_hi_r[0]} == $past(analog_as_digital & analog_active))
        else $error("analogue segments");
    a_label_hold: assert property (s_press0 |=> digit_hi_r == 7'h78
        && digit_lo_r == 7'h6d) else $error("label");
    a_led_diag: assert property ((diag_mode || error_mode)[*2] |-> diag_led_r)
        else $error("led off");
    a_led_normal: assert property (normal_mode[*2] |-> !diag_led_r)
        else $error("led on");
endmodule // display_monitor

// ==== tb/remote_panel.sv ====
`timescale 1ns/10ps
// ********************
// Remote panel button
// ********************
module remote_panel (
    input  wire  ref_clk,
    output logic mode_button = 1'b0
);
    // Press and keep held for n falling edges; a slow operator is a larger n.
    task automatic hold_for(input int n);
        mode_button = 1'b1;
        repeat (n) @(negedge ref_clk);
    endtask
    // Let go and wait; the contact reads low when released.
    task automatic release_for(input int n);
        mode_button = 1'b0;
        repeat (n) @(negedge ref_clk);
    endtask
endmodule // remote_panel

// ==== tb/tb.sv ====
`timescale 1ns/10ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin err_count++; \
    $display("ERROR %0t got %h exp %h", $time, got, exp); end end
module tb;
    localparam int          deb = 4;   // Short counts keep the run brief.
    localparam int          hold = 40;
    localparam logic [6:0]  seg_code [10] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66,
                                              7'h6d, 7'h7d, 7'h07, 7'h7f, 7'h6f};
    localparam logic [13:0] label [6] = '{{7'h78, 7'h6d}, {7'h3f, 7'h6d}, {7'h7c, 7'h77},
                                          {7'h10, 7'h78}, {7'h79, 7'h6d}, {7'h6d, 7'h50}};
    logic        ref_clk = 1'b0, sys_rst = 1'b1, mode_button;
    logic [13:0] turbine_rpm = '0, output_rpm = '0, engine_rpm = '0;
    logic        turbine_ok = 1'b0, output_ok = 1'b0, engine_ok = 1'b0, engine_fitted = 1'b0;
    logic [9:0]  switched_supply_line = '0;
    logic [7:0]  digital_in = '0;
    logic [3:0]  analog_as_digital = '0, analog_active = '0;
    logic [6:0]  digit_hi_r, digit_lo_r;
    logic        unit_dot_r, diag_led_r, normal_mode, diag_mode, error_mode;
    logic [2:0]  screen_idx;
    logic [14:0] exp_v;
    int          err_count = 0, num_checks = 0, cycles = 0;
    always #2.5 ref_clk = ~ref_clk;
    remote_panel panel (.ref_clk(ref_clk), .mode_button(mode_button));
    diag_display_formatter #(.DEB_CYCLES(deb), .HOLD_CYCLES(hold)) uut (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .mode_button(mode_button),
        .turbine_rpm(turbine_rpm), .turbine_ok(turbine_ok), .output_rpm(output_rpm),
        .output_ok(output_ok), .engine_rpm(engine_rpm), .engine_ok(engine_ok),
        .engine_fitted(engine_fitted), .switched_supply_line(switched_supply_line),
        .digital_in(digital_in), .analog_as_digital(analog_as_digital),
        .analog_active(analog_active), .digit_hi_r(digit_hi_r), .digit_lo_r(digit_lo_r),
        .unit_dot_r(unit_dot_r), .diag_led_r(diag_led_r), .normal_mode(normal_mode),
        .diag_mode(diag_mode), .error_mode(error_mode), .screen_idx(screen_idx));
    // Two decimal digits plus dot.
    function automatic logic [14:0] two(input int n, input logic dot);
        return {seg_code[n / 10], seg_code[n % 10], dot};
    endfunction
    // Speed model: dashes when missing, otherwise rounded to the step.
    function automatic logic [14:0] speed(input int rpm, input logic ok);
        int n;
        if (!ok) return {7'h40, 7'h40, 1'b0};
        if (rpm < 995) return two((rpm + 5) / 10, 1'b0);
        n = (rpm + 50) / 100;
        return two(n > 99 ? 99 : n, 1'b1);
    endfunction
    // Expected display of one screen for the present inputs.
    function automatic logic [14:0] model(input int s);
        logic [3:0] ad;
        int         v;
        ad = analog_as_digital & analog_active;
        v = switched_supply_line;
        case (s)
            0: return speed(turbine_rpm, turbine_ok);
            1: return speed(output_rpm, output_ok);
            2: return two(v / 10 > 99 ? 99 : v / 10, v % 10 >= 5);
            3: return {1'b0, digital_in[0], digital_in[1], ad[1], digital_in[3], digital_in[2],
                       ad[0], 1'b0, digital_in[4], digital_in[5], ad[3], digital_in[7],
                       digital_in[6], ad[2], 1'b0};
            4: return speed(engine_rpm, engine_ok);
            default: return {7'h40, 7'h40, 1'b0};
        endcase
    endfunction
    // Fresh inputs, then compare the screen once it has settled.
    task automatic settle(input int s);
        for (int i = 0; i < 6; i++) begin
            turbine_rpm = (i < 2) ? 14'd994 + 14'(i) : 14'(100 + $urandom % 11000);
            output_rpm = 14'(100 + $urandom % 11000);
            engine_rpm = 14'(100 + $urandom % 11000);
            // Pass 2 takes every speed away so each speed screen shows its dashes.
            turbine_ok = (i < 2) || (i != 2 && $urandom % 8 != 0);
            output_ok = (i != 2) && ($urandom % 8 != 0);
            engine_ok = (i != 2) && ($urandom % 8 != 0);
            switched_supply_line = 10'(100 + $urandom % 924);
            digital_in = 8'($urandom);
            analog_as_digital = 4'($urandom);
            analog_active = 4'($urandom);
            repeat (10) @(negedge ref_clk);
            exp_v = model(s);
            `CHK({digit_hi_r, digit_lo_r}, exp_v[14:1])
            if (s != 3) `CHK(unit_dot_r, exp_v[0])
        end
    endtask
    // Short press: label while held, next screen after release.
    task automatic step(input int s, input int nxt);
        panel.hold_for(10);
        `CHK({digit_hi_r, digit_lo_r}, label[s])
        panel.release_for(10);
        `CHK(screen_idx, 3'(nxt))
    endtask
    task automatic print_verdict();
        if (err_count == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Cut a hang short well beyond the expected run length.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 4000) begin
            err_count++;
            print_verdict();
        end
    end
    initial begin
        void'($urandom(70));
        panel.hold_for(3);
        sys_rst = 1'b0;
        panel.hold_for(2);
        panel.release_for(10);
        `CHK({diag_mode, diag_led_r}, 2'b11)
        for (int p = 0; p < 2; p++) begin
            engine_fitted = p[0];
            for (int s = 0; s <= 3 + 2 * p; s++) begin
                settle(s);
                step(s, (s == 3 + 2 * p) ? 0 : s + 1);
            end
        end
        step(0, 1);
        panel.hold_for(hold + 10);
        `CHK({digit_hi_r, digit_lo_r}, {7'h77, 7'h71})
        panel.release_for(10);
        `CHK({error_mode, diag_led_r, digit_hi_r}, {2'b11, 7'h00})
        sys_rst = 1'b1;
        repeat (3) @(negedge ref_clk);
        sys_rst = 1'b0;
        repeat (10) @(negedge ref_clk);
        `CHK({normal_mode, diag_led_r}, 2'b10)
        // Short press in normal mode keeps the mode; a long one enters error.
        panel.hold_for(10);
        panel.release_for(10);
        `CHK({normal_mode, error_mode}, 2'b10)
        panel.hold_for(hold + 10);
        panel.release_for(10);
        `CHK({error_mode, diag_led_r}, 2'b11)
        print_verdict();
    end
endmodule // tb
bind diag_display_formatter display_monitor mon (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .mode_button(mode_button),
    .turbine_ok(turbine_ok), .turbine_rpm(turbine_rpm), .output_ok(output_ok),
    .engine_ok(engine_ok), .switched_supply_line(switched_supply_line),
    .digital_in(digital_in), .analog_as_digital(analog_as_digital),
    .analog_active(analog_active), .digit_hi_r(digit_hi_r), .digit_lo_r(digit_lo_r),
    .unit_dot_r(unit_dot_r), .diag_led_r(diag_led_r), .normal_mode(normal_mode),
    .diag_mode(diag_mode), .error_mode(error_mode), .screen_idx(screen_idx));
